// ---- core/persist_filter.sv ----
// Counts how long a level has held and flags when it reached a limit
`timescale 1ns/1ps
module persist_filter
  import fault_supervisor_pkg::*;
#(
  parameter int LIMIT = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic level,
  output logic reached
);

  logic [fault_supervisor_pkg::COUNT_W-1:0] count;
  localparam logic [COUNT_W-1:0] LAST = COUNT_W'(LIMIT - 1);

  // Any gap in the level restarts the count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= COUNT_ZERO;
    end else if (!level) begin
      count <= COUNT_ZERO;
    end else if (count != LAST) begin
      count <= count + COUNT_W'(1);
    end
  end

  // High on the edge that ends the LIMIT-th consecutive cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reached <= 1'b0;
    end else begin
      reached <= level && (count == LAST);
    end
  end

endmodule // persist_filter

// ---- core/vr_fault_protection_supervisor.sv ----
// Latched fault supervisor for one regulator rail
`timescale 1ns/1ps
// Notes on behaviour
// - Undervoltage trips after the below-target compare holds 3 us.
// - Undervoltage trip drops ready and tri-states every PWM output; PWM stays low if overvoltage tripped first or in the same cycle.
// - Undervoltage ignored during target transitions and 80 us after settling.
// - Fault latches clear only by supply or enable cycling, nothing else.
// - Fault forces reference code: 1 V over, 1.5 V under, 2 V overcurrent; only the first fault's code is forced, overvoltage winning ties.
// - Soft-start overcurrent scale from max current: <40, 40-79, >=80 amps.
// - Soft-start overcurrent armed first ramp from zero plus 80 us; trips off.
// - Summed overcurrent latches after 40 us continuous excess; ready low, tri-state; PWM stays low if overvoltage tripped first or in the same cycle.
// - Summed overcurrent masked in transitions, 80 us after, and at zero target.
// - Overvoltage after 0.5 us filter drops ready, drives PWM low; PWM stays tri-stated if another fault tripped in an earlier cycle.
module vr_fault_protection_supervisor
  import fault_supervisor_pkg::*;
#(
  parameter int SETTLE_CYCLES = fault_supervisor_pkg::SETTLE_MASK_CYC,
  parameter int SUM_OC_CYCLES = fault_supervisor_pkg::SUM_OC_PERSIST_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable_in,
  input wire logic supply_ok,
  input wire logic target_transition,
  input wire logic [fault_supervisor_pkg::TARGET_W-1:0] voltage_target_code,
  input wire logic [fault_supervisor_pkg::CURRENT_W-1:0] max_current_setting,
  input wire logic below_uv_level,
  input wire logic above_ov_level,
  input wire logic above_softstart_oc_level,
  input wire logic above_summed_oc_level,
  output logic regulator_ok_out,
  output logic pwm_tristate,
  output logic pwm_force_low,
  output fault_supervisor_pkg::ref_code_t ref_level_code,
  output logic [1:0] softstart_oc_scale,
  output logic undervoltage_trip,
  output logic overvoltage_trip,
  output logic softstart_overcurrent_trip,
  output logic summed_overcurrent_trip
);

  import fault_supervisor_pkg::*;

  localparam logic [COUNT_W-1:0] SETTLE_LOAD = COUNT_W'(SETTLE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // Band selection from the max current setting

  function automatic logic [1:0] band_scale(input logic [CURRENT_W-1:0] amps);
    if (amps < ICC_BAND_MID) begin
      band_scale = SS_SCALE_200MV;
    end else if (amps < ICC_BAND_HIGH) begin
      band_scale = SS_SCALE_400MV;
    end else begin
      band_scale = SS_SCALE_800MV;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic running;
  logic transition_prev;
  logic [COUNT_W-1:0] settle_count;
  logic settle_mask;
  logic target_zero;
  logic any_fault;
  logic uv_filtered;
  logic ov_filtered;
  logic sum_oc_persisted;
  logic uv_event;
  logic ov_event;
  logic ss_oc_event;
  logic sum_oc_event;
  logic ss_armed;
  ss_state_t ss_state;
  ss_state_t next_ss_state;

  // Supply or enable low holds everything but softstart_oc_scale and transition_prev in its cleared state
  assign running = enable_in && supply_ok;
  assign target_zero = (voltage_target_code == TARGET_ZERO);
  // Edge after the fall is covered too, before the counter has loaded
  assign settle_mask = target_transition || transition_prev || (settle_count != COUNT_ZERO);
  assign any_fault = undervoltage_trip || overvoltage_trip || softstart_overcurrent_trip || summed_overcurrent_trip;
  assign ss_armed = (ss_state == SS_RAMP) || (ss_state == SS_SETTLE);

  ////////////////////////////////////////////////////////////////////////////
  // Settle window after each target transition

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      transition_prev <= 1'b0;
    end else begin
      transition_prev <= target_transition;
    end
  end

  // Reloaded on each end of transition so back-to-back moves keep the mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      settle_count <= COUNT_ZERO;
    end else if (!running || target_transition) begin
      settle_count <= COUNT_ZERO;
    end else if (transition_prev) begin
      settle_count <= SETTLE_LOAD;
    end else if (settle_count != COUNT_ZERO) begin
      settle_count <= settle_count - COUNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator filters

  // Mask also restarts the filter so a masked excursion never counts
  persist_filter #(
    .LIMIT(UV_FILTER_CYC)
  ) uv_filter (
    .clk(clk),
    .rstn(rstn),
    .level(below_uv_level && running && !settle_mask),
    .reached(uv_filtered)
  );

  // Zero target leaves no overvoltage reference to compare against
  persist_filter #(
    .LIMIT(OV_FILTER_CYC)
  ) ov_filter (
    .clk(clk),
    .rstn(rstn),
    .level(above_ov_level && running && !target_zero),
    .reached(ov_filtered)
  );

  persist_filter #(
    .LIMIT(SUM_OC_CYCLES)
  ) sum_oc_filter (
    .clk(clk),
    .rstn(rstn),
    .level(above_summed_oc_level && running && !settle_mask && !target_zero),
    .reached(sum_oc_persisted)
  );

  assign uv_event = uv_filtered && running;
  assign ov_event = ov_filtered && running;
  assign sum_oc_event = sum_oc_persisted && running;
  // Soft-start trip acts at once, no filter
  assign ss_oc_event = above_softstart_oc_level && ss_armed && running;

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start window: first ramp from zero and its settle time only

  always_comb begin
    next_ss_state = ss_state;
    case (ss_state)
      SS_WAIT: begin
        // Output sits at zero until the first ramp after enable
        if (target_transition) begin
          next_ss_state = SS_RAMP;
        end
      end
      SS_RAMP: begin
        if (!target_transition) begin
          next_ss_state = SS_SETTLE;
        end
      end
      SS_SETTLE: begin
        if (!transition_prev && settle_count == COUNT_W'(1)) begin
          next_ss_state = SS_DONE;
        end
      end
      SS_DONE: begin
        next_ss_state = SS_DONE;
      end
      default: begin
        next_ss_state = SS_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ss_state <= SS_WAIT;
    end else if (!running) begin
      ss_state <= SS_WAIT;
    end else begin
      ss_state <= next_ss_state;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      softstart_oc_scale <= SS_SCALE_200MV;
    end else begin
      softstart_oc_scale <= band_scale(max_current_setting);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches

  // Only a low on enable or supply clears; no software path exists
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      undervoltage_trip <= 1'b0;
      overvoltage_trip <= 1'b0;
      softstart_overcurrent_trip <= 1'b0;
      summed_overcurrent_trip <= 1'b0;
    end else if (!running) begin
      undervoltage_trip <= 1'b0;
      overvoltage_trip <= 1'b0;
      softstart_overcurrent_trip <= 1'b0;
      summed_overcurrent_trip <= 1'b0;
    end else begin
      undervoltage_trip <= undervoltage_trip || uv_event;
      overvoltage_trip <= overvoltage_trip || ov_event;
      softstart_overcurrent_trip <= softstart_overcurrent_trip || ss_oc_event;
      summed_overcurrent_trip <= summed_overcurrent_trip || sum_oc_event;
    end
  end

  // Reported code is taken once; same-cycle ties favour overvoltage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_level_code <= REF_NORMAL;
    end else if (!running) begin
      ref_level_code <= REF_NORMAL;
    end else if (!any_fault) begin
      if (ov_event) begin
        ref_level_code <= REF_1V0;
      end else if (uv_event) begin
        ref_level_code <= REF_1V5;
      end else if (ss_oc_event || sum_oc_event) begin
        ref_level_code <= REF_2V0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power stage and ready outputs

  // PWM action follows the first fault, so a later fault cannot flip the stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_tristate <= 1'b0;
      pwm_force_low <= 1'b0;
    end else if (!running) begin
      pwm_tristate <= 1'b0;
      pwm_force_low <= 1'b0;
    end else if (!any_fault) begin
      if (ov_event) begin
        pwm_force_low <= 1'b1;
      end else if (uv_event || ss_oc_event || sum_oc_event) begin
        pwm_tristate <= 1'b1;
      end
    end
  end

  // Ready needs a running rail at a nonzero target outside a transition and no fault; the settle window does not hold it low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regulator_ok_out <= 1'b0;
    end else if (!running || any_fault || uv_event || ov_event || ss_oc_event || sum_oc_event) begin
      regulator_ok_out <= 1'b0;
    end else begin
      regulator_ok_out <= !target_zero && !target_transition;
    end
  end

endmodule // vr_fault_protection_supervisor

// ---- shared/fault_supervisor_pkg.sv ----
// Constants and types shared by the fault supervisor and its filter counter
package fault_supervisor_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  localparam int CLK_PERIOD_PS = 8000;

  ////////////////////////////////////////////////////////////////////////////
  // Printed times, in their own unit
  localparam int UV_FILTER_NS = 3000;
  localparam int OV_FILTER_NS = 500;
  localparam int SETTLE_MASK_NS = 80000;
  localparam int SUM_OC_PERSIST_NS = 40000;

  // Least times round up to whole cycles
  localparam int UV_FILTER_CYC = (UV_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OV_FILTER_CYC = (OV_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_MASK_CYC = (SETTLE_MASK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SUM_OC_PERSIST_CYC = (SUM_OC_PERSIST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int COUNT_W = 16;
  localparam int TARGET_W = 8;
  localparam int CURRENT_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start overcurrent bands, amps, and scale codes
  localparam logic [CURRENT_W-1:0] ICC_BAND_MID = 8'h28;
  localparam logic [CURRENT_W-1:0] ICC_BAND_HIGH = 8'h50;
  localparam logic [1:0] SS_SCALE_200MV = 2'h0;
  localparam logic [1:0] SS_SCALE_400MV = 2'h1;
  localparam logic [1:0] SS_SCALE_800MV = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Reference level forced after a fault
  typedef enum logic [1:0] {
    REF_NORMAL = 2'h0,
    REF_1V0 = 2'h1,
    REF_1V5 = 2'h2,
    REF_2V0 = 2'h3
  } ref_code_t;

  // Start-up window for soft-start overcurrent
  typedef enum logic [3:0] {
    SS_WAIT = 4'h1,
    SS_RAMP = 4'h2,
    SS_SETTLE = 4'h4,
    SS_DONE = 4'h8
  } ss_state_t;

  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [TARGET_W-1:0] TARGET_ZERO = 8'h00;

endpackage

// ---- testbench/phase_stage_model.sv ----
// Behavioural phase power stage behind the PWM outputs
`timescale 1ns/1ps
module phase_stage_model (
  input wire logic clk,
  input wire logic pwm_tristate,
  input wire logic pwm_force_low,
  output logic high_side_on,
  output logic low_side_on
);
  logic phase = 1'b0;
  // Free-running switching while no fault holds the outputs
  always @(posedge clk) phase <= ~phase;
  // Low wins over tri-state, as the first-fault mode holds only one
  assign high_side_on = !pwm_tristate && !pwm_force_low && phase;
  assign low_side_on = pwm_force_low || (!pwm_tristate && !phase);
endmodule // phase_stage_model

// ---- testbench/vr_fault_protection_supervisor_properties.sv ----
// Checker for the latched fault supervisor
`timescale 1ns/1ps
module vr_fault_protection_supervisor_properties
  import fault_supervisor_pkg::*;
#(
  parameter int SETTLE_CYCLES = 20,
  parameter int SUM_OC_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable_in,
  input wire logic supply_ok,
  input wire logic [TARGET_W-1:0] voltage_target_code,
  input wire logic [CURRENT_W-1:0] max_current_setting,
  input wire logic target_transition,
  input wire logic below_uv_level,
  input wire logic above_summed_oc_level,
  input wire logic above_softstart_oc_level,
  input wire logic regulator_ok_out,
  input wire logic pwm_tristate,
  input wire logic pwm_force_low,
  input wire ref_code_t ref_level_code,
  input wire logic [1:0] softstart_oc_scale,
  input wire logic undervoltage_trip,
  input wire logic overvoltage_trip,
  input wire logic softstart_overcurrent_trip,
  input wire logic summed_overcurrent_trip
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [3:0] trips;
  logic [1:0] band;
  logic [15:0] uv_run;
  logic [15:0] oc_run;
  logic run;
  assign trips = {overvoltage_trip, undervoltage_trip, softstart_overcurrent_trip, summed_overcurrent_trip};
  assign band = (max_current_setting < ICC_BAND_MID) ? SS_SCALE_200MV :
                (max_current_setting < ICC_BAND_HIGH) ? SS_SCALE_400MV : SS_SCALE_800MV;
  assign run = enable_in && supply_ok;
  ////////////////////////////////////////////////////////////////////////////
  // Run lengths of the undervoltage and summed overcurrent comparators; saturate so a long fault never wraps
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) uv_run <= 16'h0000;
    else if (!below_uv_level) uv_run <= 16'h0000;
    else if (uv_run != 16'hffff) uv_run <= uv_run + 16'h0001;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) oc_run <= 16'h0000;
    else if (!above_summed_oc_level) oc_run <= 16'h0000;
    else if (oc_run != 16'hffff) oc_run <= oc_run + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_uv_filter_time: assert property ($rose(undervoltage_trip) |-> $past(uv_run) >= UV_FILTER_CYC)
    else $error("undervoltage trip before filter time");
  a_uv_safe_state: assert property (undervoltage_trip |-> !regulator_ok_out && (pwm_tristate || pwm_force_low))
    else $error("undervoltage trip without safe state");
  a_uv_masked: assert property ($rose(undervoltage_trip) |-> !$past(target_transition, 2))
    else $error("undervoltage trip during transition");
  a_latch_holds: assert property (run |=> (trips & $past(trips)) == $past(trips))
    else $error("fault latch cleared while running");
  a_ov_code_low: assert property ($rose(overvoltage_trip) && $past(trips) == 4'h0 |->
    ref_level_code == REF_1V0 && pwm_force_low && !regulator_ok_out)
    else $error("overvoltage reaction wrong");
  a_scale_band: assert property (1'b1 |=> softstart_oc_scale == $past(band))
    else $error("soft-start scale band wrong");
  a_ss_cause: assert property ($rose(softstart_overcurrent_trip) |-> $past(above_softstart_oc_level))
    else $error("soft-start trip without cause");
  a_sum_persist: assert property ($rose(summed_overcurrent_trip) |-> $past(oc_run) >= SUM_OC_CYCLES
    && $past(voltage_target_code, 2) != TARGET_ZERO && !$past(target_transition, 2))
    else $error("summed trip too early or masked");
  a_first_code: assert property (run && ref_level_code != REF_NORMAL |=> $stable(ref_level_code))
    else $error("reported fault code changed");
  c_uv: cover property ($rose(undervoltage_trip));
  c_ov: cover property ($rose(overvoltage_trip));
  c_ss: cover property ($rose(softstart_overcurrent_trip));
  c_sum: cover property ($rose(summed_overcurrent_trip));
endmodule // vr_fault_protection_supervisor_properties

bind vr_fault_protection_supervisor vr_fault_protection_supervisor_properties #(
  .SETTLE_CYCLES(SETTLE_CYCLES), .SUM_OC_CYCLES(SUM_OC_CYCLES)
) props_i (.clk(clk), .rstn(rstn), .enable_in(enable_in), .supply_ok(supply_ok),
  .voltage_target_code(voltage_target_code), .max_current_setting(max_current_setting),
  .target_transition(target_transition), .below_uv_level(below_uv_level),
  .above_summed_oc_level(above_summed_oc_level), .above_softstart_oc_level(above_softstart_oc_level),
  .regulator_ok_out(regulator_ok_out), .pwm_tristate(pwm_tristate), .pwm_force_low(pwm_force_low),
  .ref_level_code(ref_level_code), .softstart_oc_scale(softstart_oc_scale),
  .undervoltage_trip(undervoltage_trip), .overvoltage_trip(overvoltage_trip),
  .softstart_overcurrent_trip(softstart_overcurrent_trip), .summed_overcurrent_trip(summed_overcurrent_trip));

// ---- testbench/vr_fault_protection_supervisor_tb_top.sv ----
// Self-checking bench for the latched fault supervisor
`timescale 1ns/1ps
module vr_fault_protection_supervisor_tb_top;
  import fault_supervisor_pkg::*;
  logic clk, rstn, en, sup, tt, ready, tri_o, low_o, uv, ov, ss, so, hs, ls;
  logic [7:0] tgt, mc;
  logic [3:0] lv;
  logic [1:0] scale;
  ref_code_t code;
  int mismatches, checked, cycles;
  logic [7:0] row_in [6] = '{8'h00, 8'h27, 8'h28, 8'h4f, 8'h50, 8'hff};
  logic [1:0] row_exp [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
  vr_fault_protection_supervisor #(.SETTLE_CYCLES(20), .SUM_OC_CYCLES(10)) vr_fault_protection_supervisor_i (
    .clk(clk), .rstn(rstn), .enable_in(en), .supply_ok(sup), .target_transition(tt),
    .voltage_target_code(tgt), .max_current_setting(mc), .below_uv_level(lv[0]), .above_ov_level(lv[1]),
    .above_softstart_oc_level(lv[2]), .above_summed_oc_level(lv[3]), .regulator_ok_out(ready),
    .pwm_tristate(tri_o), .pwm_force_low(low_o), .ref_level_code(code), .softstart_oc_scale(scale),
    .undervoltage_trip(uv), .overvoltage_trip(ov), .softstart_overcurrent_trip(ss), .summed_overcurrent_trip(so));
  phase_stage_model phase_stage_model_i (.clk(clk), .pwm_tristate(tri_o), .pwm_force_low(low_o),
    .high_side_on(hs), .low_side_on(ls));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Comparator held for n sampled edges, then flags given time to latch
  task hold(input int sel, input int n);
    @(posedge clk) lv[sel] <= 1'b1;
    cyc(n);
    lv[sel] <= 1'b0;
    cyc(3);
    #1;
  endtask
  task recycle();
    @(posedge clk) en <= 1'b0;
    cyc(2);
    #1;
    chk("flags after enable low", 8'h00, {4'h0, ov, uv, ss, so});
    @(posedge clk) en <= 1'b1;
    cyc(2);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    // Longest path is about 1930 cycles; ceiling leaves wide margin
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, tt, lv, mc, mismatches, checked, cycles} = '0;
    {en, sup} = 2'b11;
    tgt = 8'h40;
    cyc(4);
    #1;
    chk("reset outputs", 8'h00, {ready, tri_o, low_o, code, uv, ov, so});
    cyc(4);
    rstn <= 1'b1;
    cyc(3);
    #1;
    chk("ready after reset", 8'h01, {7'h0, ready});
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) mc <= row_in[i];
      cyc(2);
      #1;
      chk("scale", {6'h0, row_exp[i]}, {6'h0, scale});
    end
    $display("band test done");
    @(posedge clk) tt <= 1'b1;
    hold(0, 400);
    chk("uv in transition", 8'h00, {7'h0, uv});
    @(posedge clk) tt <= 1'b0;
    hold(0, 375);
    chk("uv in settle window", 8'h00, {7'h0, uv});
    hold(0, 374);
    chk("uv short", 8'h00, {7'h0, uv});
    hold(0, 375);
    chk("uv trip", 8'h1a, {3'h0, uv, tri_o, ready, code});
    chk("stage off", 8'h00, {6'h0, hs, ls});
    hold(1, 70);
    chk("second fault", 8'h36, {2'h0, ov, uv, low_o, tri_o, code});
    cyc(10);
    chk("uv latch", 8'h01, {7'h0, uv});
    @(posedge clk) sup <= 1'b0;
    cyc(2);
    #1;
    chk("uv after supply low", 8'h00, {6'h0, uv, ov});
    @(posedge clk) sup <= 1'b1;
    $display("undervoltage test done");
    hold(1, 62);
    chk("ov short", 8'h00, {7'h0, ov});
    hold(1, 63);
    chk("ov trip", 8'h19, {3'h0, ov, low_o, tri_o, code});
    chk("stage low", 8'h01, {6'h0, hs, ls});
    recycle();
    $display("overvoltage test done");
    @(posedge clk) tgt <= 8'h00;
    hold(3, 20);
    chk("sum oc at zero target", 8'h00, {7'h0, so});
    @(posedge clk) tgt <= 8'h40;
    cyc(2);
    hold(3, 9);
    chk("sum oc short", 8'h00, {7'h0, so});
    hold(3, 10);
    chk("sum oc trip", 8'h1b, {3'h0, so, tri_o, ready, code});
    @(posedge clk) tgt <= 8'h00;
    recycle();
    $display("summed overcurrent test done");
    @(posedge clk) tt <= 1'b1;
    cyc(3);
    tt <= 1'b0;
    hold(2, 1);
    chk("soft-start trip", 8'h1b, {3'h0, ss, tri_o, ready, code});
    recycle();
    hold(2, 5);
    chk("soft-start unarmed", 8'h00, {7'h0, ss});
    // A later ramp after the first one settled must not re-arm
    @(posedge clk) tt <= 1'b1;
    cyc(3);
    tt <= 1'b0;
    cyc(30);
    @(posedge clk) tt <= 1'b1;
    hold(2, 5);
    chk("soft-start second ramp", 8'h00, {7'h0, ss});
    @(posedge clk) tt <= 1'b0;
    $display("soft-start test done");
    conclude();
  end
endmodule // vr_fault_protection_supervisor_tb_top
